/* rf_timer.sv */
// Countdown timer with tick prescaler and auto restart, AHB-Lite slave.
// Assumes one clock hclk at 50 MHz and asynchronous active-low hresetn;
// the only bus slave, so its hreadyout is the bus hready.
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rf_timer
   import rf_timer_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Interrupt
   output logic irq
);

   timer_cfg_t cfg_r;
   bus_state_t bus_st_r;
   bus_req_t req_r;
   logic [31:0] preset_r;
   logic [31:0] count_r;
   logic running_r;
   logic launch_r;
   logic status_r;
   logic mask_r;
   logic [31:0] nco_r;
   logic [7:0] div_cnt_r;
   logic hreadyout_r;
   logic [31:0] hrdata_r;
   logic hresp_r;
   logic irq_r;

   logic accept;
   logic wr_go;
   logic rd_go;
   logic [32:0] nco_sum;
   logic base_tick;
   logic [7:0] div_mask;
   logic tick;
   logic expire;
   logic status_clr;
   logic [31:0] rd_data;

   // Address phase taken only when idle and the bus is ready
   assign accept = hsel && htrans[1] && hready && (bus_st_r == BUS_IDLE);
   assign wr_go = (bus_st_r == BUS_WAIT) && req_r.write && req_r.word;
   assign rd_go = (bus_st_r == BUS_WAIT) && !req_r.write;

   // Bus phase tracking: every transfer gets one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_st_r <= BUS_IDLE;
         req_r <= '0;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         hresp_r <= 1'b0; // Always OKAY
         case (bus_st_r)
            BUS_IDLE: begin
               if (accept) begin
                  bus_st_r <= BUS_WAIT;
                  req_r.addr <= {haddr[7:2], 2'b00};
                  req_r.write <= hwrite;
                  req_r.word <= (hsize == HSIZE_WORD);
                  hreadyout_r <= 1'b0;
               end
            end
            BUS_WAIT: begin
               bus_st_r <= BUS_IDLE;
               hreadyout_r <= 1'b1;
            end
            default: begin
               bus_st_r <= BUS_IDLE;
               hreadyout_r <= 1'b1;
            end
         endcase
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (req_r.addr)
         OFS_CTRL: begin
            rd_data[POS_RUN_ALLOW] = cfg_r.run_allow_bit;
            rd_data[POS_AUTO_RESTART] = cfg_r.auto_restart_bit;
            rd_data[POS_DIVIDER_USE] = cfg_r.divider_use_bit;
            rd_data[POS_DIV_SEL +: 3] = cfg_r.tick_divider_select;
         end
         OFS_PRESET: rd_data = preset_r;
         OFS_VALUE: rd_data = count_r;
         OFS_STATUS: rd_data[POS_EXPIRED] = status_r;
         OFS_MASK: rd_data[POS_EXPIRED] = mask_r;
         OFS_STATE: rd_data[0] = running_r;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Read data register, loaded in the wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_go) begin
         hrdata_r <= rd_data;
      end
   end

   // Configuration, preset and mask writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r.tick_divider_select <= DIV_SEL_RST;
         cfg_r.divider_use_bit <= DIVIDER_USE_RST;
         cfg_r.auto_restart_bit <= AUTO_RESTART_RST;
         cfg_r.run_allow_bit <= RUN_ALLOW_RST;
         preset_r <= PRESET_RST;
         mask_r <= MASK_RST;
      end else if (wr_go) begin
         if (req_r.addr == OFS_CTRL) begin
            cfg_r.run_allow_bit <= hwdata[POS_RUN_ALLOW];
            cfg_r.auto_restart_bit <= hwdata[POS_AUTO_RESTART];
            cfg_r.divider_use_bit <= hwdata[POS_DIVIDER_USE];
            cfg_r.tick_divider_select <= hwdata[POS_DIV_SEL +: 3];
         end
         if (req_r.addr == OFS_PRESET) begin
            preset_r <= hwdata;
         end
         if (req_r.addr == OFS_MASK) begin
            mask_r <= hwdata[POS_EXPIRED];
         end
      end
   end

   // Launch pulse: writing one to the launch bit, reads back zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         launch_r <= 1'b0;
      end else begin
         launch_r <= wr_go && (req_r.addr == OFS_CTRL) && hwdata[POS_LAUNCH];
      end
   end

   // Phase accumulator makes the 13.56 MHz tick on average
   assign nco_sum = {1'b0, nco_r} + {1'b0, NCO_INC};
   assign base_tick = nco_sum[32];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nco_r <= 32'h0000_0000;
      end else begin
         nco_r <= nco_sum[31:0];
      end
   end

   // Prescaler: divide base tick by 2 << select
   assign div_mask = 8'((9'h002 << cfg_r.tick_divider_select) - 9'h001);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_r <= 8'h00;
      end else if (base_tick) begin
         div_cnt_r <= div_cnt_r + 8'h01;
      end
   end

   // Tick selection between undivided and prescaled rate
   always_comb begin
      if (cfg_r.divider_use_bit) begin
         tick = base_tick && ((div_cnt_r & div_mask) == div_mask);
      end else begin
         tick = base_tick;
      end
   end

   // Expiry when the count reaches zero on a tick
   assign expire = running_r && cfg_r.run_allow_bit && tick &&
                   (count_r <= 32'h0000_0001);

   // Countdown state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= COUNT_RST;
         running_r <= 1'b0;
      end else if (!cfg_r.run_allow_bit) begin
         running_r <= 1'b0;
      end else if (launch_r) begin
         count_r <= preset_r;
         running_r <= 1'b1;
      end else if (expire) begin
         if (cfg_r.auto_restart_bit) begin
            count_r <= preset_r;
         end else begin
            count_r <= COUNT_RST;
            running_r <= 1'b0;
         end
      end else if (running_r && tick) begin
         count_r <= count_r - 32'h0000_0001;
      end
   end

   // Sticky expiry flag, write one to clear, set wins
   assign status_clr = wr_go && (req_r.addr == OFS_STATUS) &&
                       hwdata[POS_EXPIRED];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_r <= STATUS_RST;
      end else begin
         status_r <= expire || (status_r && !status_clr);
      end
   end

   // Interrupt level from unmasked status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= status_r && mask_r;
      end
   end

   // Outputs
   assign hreadyout = hreadyout_r;
   assign hrdata = hrdata_r;
   assign hresp = hresp_r;
   assign irq = irq_r;

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_undivided;
      !cfg_r.divider_use_bit |-> (tick == base_tick);
   endproperty
   a_undivided: assert property (p_undivided)
      else $error("undivided tick differs from base tick");

   property p_divided;
      cfg_r.divider_use_bit && tick |->
         (((div_cnt_r + 8'h01) & div_mask) == 8'h00);
   endproperty
   a_divided: assert property (p_divided)
      else $error("prescaled tick off its divide ratio");

   property p_slowest;
      cfg_r.divider_use_bit && (cfg_r.tick_divider_select == 3'h7) &&
         tick |-> (div_cnt_r == 8'hff);
   endproperty
   a_slowest: assert property (p_slowest)
      else $error("select 7 tick not every 256 base ticks");

   property p_fastest;
      cfg_r.divider_use_bit && (cfg_r.tick_divider_select == 3'h0) &&
         base_tick |-> (tick == div_cnt_r[0]);
   endproperty
   a_fastest: assert property (p_fastest)
      else $error("select 0 tick not every second base tick");

   property p_stop;
      expire && !cfg_r.auto_restart_bit && !launch_r |=>
         (count_r == 32'h0000_0000) && !running_r;
   endproperty
   a_stop: assert property (p_stop)
      else $error("timer did not stop at zero");

   property p_reload;
      expire && cfg_r.auto_restart_bit && !launch_r |=>
         (count_r == $past(preset_r)) && running_r;
   endproperty
   a_reload: assert property (p_reload)
      else $error("timer did not reload preset");

   property p_run_allow;
      !cfg_r.run_allow_bit |=> !running_r;
   endproperty
   a_run_allow: assert property (p_run_allow)
      else $error("timer running without run allow");

   property p_launch;
      launch_r && cfg_r.run_allow_bit |=>
         running_r && (count_r == $past(preset_r));
   endproperty
   a_launch: assert property (p_launch)
      else $error("launch did not start the timer");

   property p_decrement;
      running_r && cfg_r.run_allow_bit && tick && !launch_r &&
         (count_r > 32'h0000_0001) |=> count_r == $past(count_r) - 32'h1;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("count did not drop by one on tick");

   property p_flag;
      expire |=> status_r ##1 (irq_r == $past(mask_r));
   endproperty
   a_flag: assert property (p_flag)
      else $error("expiry not flagged");

   property p_bus_wait;
      accept |=> !hreadyout_r ##1 hreadyout_r;
   endproperty
   a_bus_wait: assert property (p_bus_wait)
      else $error("bus answer not after one wait state");

   c_launch: cover property (launch_r && cfg_r.run_allow_bit);
   c_stop: cover property (expire && !cfg_r.auto_restart_bit);
   c_reload: cover property (expire && cfg_r.auto_restart_bit);
   c_irq: cover property (irq_r);

endmodule // rf_timer
`default_nettype wire

/* rf_timer_pkg.sv */
// Constants and types for the contactless-interface countdown timer.
// Assumes a 50 MHz bus clock and an AHB-Lite register port.
package rf_timer_pkg;

   // Clock rates
   localparam longint unsigned CLK_HZ = 64'd50_000_000;
   localparam longint unsigned INTF_CLK_HZ = 64'd13_560_000;
   localparam int unsigned NCO_BITS = 32;
   // Phase step that makes the interface tick rate out of the bus clock
   localparam logic [31:0] NCO_INC = 32'((INTF_CLK_HZ << NCO_BITS) / CLK_HZ);

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PRESET = 8'h04;
   localparam logic [7:0] OFS_VALUE = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_STATE = 8'h14;

   // Control, status and mask field positions
   localparam int unsigned POS_RUN_ALLOW = 0;
   localparam int unsigned POS_AUTO_RESTART = 1;
   localparam int unsigned POS_DIVIDER_USE = 2;
   localparam int unsigned POS_DIV_SEL = 3;
   localparam int unsigned POS_LAUNCH = 6;
   localparam int unsigned POS_EXPIRED = 0;

   // Reset values
   localparam logic [2:0] DIV_SEL_RST = 3'h0;
   localparam logic DIVIDER_USE_RST = 1'b0;
   localparam logic AUTO_RESTART_RST = 1'b0;
   localparam logic RUN_ALLOW_RST = 1'b0;
   localparam logic [31:0] PRESET_RST = 32'h0000_0000;
   localparam logic [31:0] COUNT_RST = 32'h0000_0000;
   localparam logic STATUS_RST = 1'b0;
   localparam logic MASK_RST = 1'b0;

   // Bus constants
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Timer configuration as software sets it
   typedef struct packed {
      logic [2:0] tick_divider_select;
      logic divider_use_bit;
      logic auto_restart_bit;
      logic run_allow_bit;
   } timer_cfg_t;

   // Captured address phase
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic word;
   } bus_req_t;

   // Bus slave phases
   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_WAIT = 1'b1
   } bus_state_t;

endpackage

/* testbench.sv */
// Self-checking bench for the countdown timer behind its AHB-Lite port.
// Assumes the timer is the only bus slave, so hready is hreadyout.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import rf_timer_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int n_errors = 0;
   int n_compared = 0;
   wire logic hready = hreadyout;

   rf_timer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hrdata, .hresp, .irq);

   // Bus clock, 20 ns period
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic report_and_stop();
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rng(input string nm, input logic [31:0] lo, hi, g);
      n_compared++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         n_errors++;
         $display("Error %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask

   // One single word transfer; called just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      do @(posedge hclk);
      while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk);
      while (hready !== 1'b1);
      rd = hrdata;
      // Response sampled with the data, must always be OKAY
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
         input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   function automatic logic [31:0] ctrl(input logic run, ar, du,
         input logic [2:0] sel, input logic go);
      return {25'h0, go, sel, du, ar, run};
   endfunction

   // Reset values, unmapped read, launch refused without run-allow
   task automatic t_reset();
      logic [7:0] ofs [7] = '{OFS_CTRL, OFS_PRESET, OFS_VALUE, OFS_STATUS,
         OFS_MASK, OFS_STATE, 8'h1c};
      foreach (ofs[i]) rchk("reset read", ofs[i], 32'h0);
      chk("irq at reset", 32'h0, {31'h0, irq});
      bus(1'b1, OFS_CTRL, 32'hffff_fffe);
      rchk("ctrl readback", OFS_CTRL, 32'h0000_003e);
      rchk("state no run", OFS_STATE, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h0);
   endtask

   // Ticks counted over a span of c bus clocks against the selected rate
   task automatic t_rate(input logic du, input logic [2:0] sel, input int c);
      longint t;
      t = (longint'(c + 4) * INTF_CLK_HZ / CLK_HZ) >> (du ? sel + 1 : 0);
      bus(1'b1, OFS_PRESET, 32'hffff_ffff);
      bus(1'b1, OFS_CTRL, ctrl(1'b1, 1'b0, du, sel, 1'b1));
      repeat (c) @(posedge hclk);
      bus(1'b0, OFS_VALUE, 32'h0);
      rng("count after span", 32'hffff_ffff - 32'(t) - 32'h2,
         32'hffff_ffff - 32'(t) + 32'h2, rd);
   endtask

   // One-shot expiry: stop at zero, sticky flag, mask and clear
   task automatic t_oneshot();
      bus(1'b1, OFS_PRESET, 32'h3);
      bus(1'b1, OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h0, 1'b1));
      repeat (40) @(posedge hclk);
      rchk("value at expiry", OFS_VALUE, 32'h0);
      rchk("state at expiry", OFS_STATE, 32'h0);
      rchk("expired flag", OFS_STATUS, 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, OFS_MASK, 32'h1);
      repeat (3) @(posedge hclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      bus(1'b1, OFS_STATUS, 32'h1);
      repeat (3) @(posedge hclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rchk("flag cleared", OFS_STATUS, 32'h0);
   endtask

   // Auto restart keeps running; clearing run-allow freezes the count
   task automatic t_reload();
      logic [31:0] v;
      bus(1'b1, OFS_PRESET, 32'd100);
      bus(1'b1, OFS_CTRL, ctrl(1'b1, 1'b1, 1'b0, 3'h0, 1'b1));
      repeat (1000) @(posedge hclk);
      rchk("state reload", OFS_STATE, 32'h1);
      bus(1'b0, OFS_VALUE, 32'h0);
      rng("value reload", 32'd1, 32'd100, rd);
      rchk("flag reload", OFS_STATUS, 32'h1);
      chk("irq reload", 32'h1, {31'h0, irq});
      bus(1'b1, OFS_CTRL, ctrl(1'b0, 1'b1, 1'b0, 3'h0, 1'b0));
      bus(1'b0, OFS_VALUE, 32'h0);
      v = rd;
      repeat (100) @(posedge hclk);
      rchk("value frozen", OFS_VALUE, v);
      rchk("state stopped", OFS_STATE, 32'h0);
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (90000) @(posedge hclk);
      n_errors++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_rate(1'b0, 3'h7, 300);
      for (int s = 0; s < 8; s++) t_rate(1'b1, 3'(s), 300 << s);
      t_oneshot();
      t_reload();
      // Reset again with the timer stopped and its flag set: all state must fall back to zero
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
